// file: rtl/ffp_defines.vh
`ifndef FFP_DEFINES_VH
`define FFP_DEFINES_VH
// ============================================================
// selector codes
`define FFP_SEL_CMD 4'h0
`define FFP_SEL_ADDR_A 4'h1
`define FFP_SEL_ADDR_B 4'h2
`define FFP_SEL_ADDR_C 4'h3
`define FFP_SEL_ADDR_D 4'h4
`define FFP_SEL_DATA 4'h5
// ============================================================
// command codes
`define FFP_CMD_NONE 16'h0000
`define FFP_CMD_READ 16'h0011
`define FFP_CMD_WP 16'h0012
`define FFP_CMD_WPL 16'h0022
`define FFP_CMD_EWP 16'h0032
`define FFP_CMD_CMD_ERASE_PAGE_WRITE_LOCK 16'h0042
`define FFP_CMD_EA 16'h0013
`define FFP_CMD_LOCK_SET 16'h0014
`define FFP_CMD_LOCK_CLR 16'h0024
`define FFP_CMD_LOCK_QRY 16'h0015
`define FFP_CMD_NVM_SET 16'h0034
`define FFP_CMD_NVM_CLR 16'h0044
`define FFP_CMD_NVM_QRY 16'h0025
`define FFP_CMD_SEC_SET 16'h0054
`define FFP_CMD_SEC_QRY 16'h0035
`define FFP_CMD_MEM_WR 16'h001F
`define FFP_CMD_CTRL_SEL 16'h0016
`define FFP_CMD_VER_QRY 16'h001E
// ============================================================
// reset values
`define FFP_RST_ADDR 32'h0000_0000
`define FFP_RST_WORD 16'h0000
`endif

// file: rtl/ffp_fifo.v
`timescale 1ns/1ns
// ============================================================
// small synchronous fifo, honest full and empty
module ffp_fifo #(
  parameter WIDTH = 48,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  input wire en_i,
  // fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // storage, no reset needed
  reg [AW:0] wr_q; // write pointer with wrap bit
  reg [AW:0] rd_q; // read pointer with wrap bit
  wire full_w = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty_w = (wr_q == rd_q);
  assign in_ready_o = !full_w;
  assign out_valid_o = !empty_w;
  assign out_data_o = mem_q[rd_q[AW-1:0]];
  // pointers advance only on accepted transfers
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else if (en_i) begin
      if (in_valid_i && !full_w) wr_q <= wr_q + 1'b1;
      if (out_ready_i && !empty_w) rd_q <= rd_q + 1'b1;
    end
  end
  // storage write
  always @(posedge clk_i) begin
    if (en_i && in_valid_i && !full_w) mem_q[wr_q[AW-1:0]] <= in_data_i;
  end
endmodule // ffp_fifo

// file: rtl/ffp_port.v
`timescale 1ns/1ns
`include "ffp_defines.vh"
module ffp_port #(
  parameter DW = 16, // 16 on large parts, 8 on small
  parameter PAGE_BITS = 8, // byte-address bits inside one page
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  // clock, enable and reset
  input wire clk_i,
  input wire en_i,
  input wire arst_n_i,
  // mode straps
  input wire test_select_i,
  input wire prog_enable_a_i,
  input wire prog_enable_b_i,
  input wire prog_enable_c_i,
  output wire mode_active_o,
  // programmer handshake pins
  input wire cmd_strobe_n_i,
  input wire bus_output_enable_n_i,
  input wire [3:0] field_selector_i,
  input wire [DW-1:0] prog_data_bus_i,
  output wire [DW-1:0] prog_data_bus_o,
  output wire prog_data_bus_oe_o,
  output wire port_ready_out_o,
  output wire port_ready_out_oe_o,
  output wire bus_valid_out_n_o,
  output wire bus_valid_out_oe_o,
  // flash controller request stream
  output wire req_valid_o,
  input wire req_ready_i,
  output wire [15:0] req_cmd_o,
  output wire [31:0] req_addr_o,
  // operation kinds: 0 data write, 1 read, 2 flush, 3 command start
  output wire [1:0] req_kind_o,
  output wire [DW-1:0] req_data_o,
  // flash controller answer for reads and queries
  input wire rsp_valid_i,
  input wire [DW-1:0] rsp_data_i
);
  // ============================================================
  // reset release and pin synchronisers
  reg [1:0] rst_sync_q; // reset release chain
  // internal reset asserts at once and releases on a clock edge, so no
  // flop sees the release in mid-setup; the chain ignores en_i so that
  // reset can still end while the rest of the port is frozen
  // shift ones in after the external reset lets go
  wire rst_n = rst_sync_q[1];
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  // pins cross two flops before any logic looks at them
  localparam SW = 4 + 4 + DW + 2; // straps, selector, data, strobe, oe
  // the whole pin group gets one flop pair per bit
  reg [SW-1:0] meta_q; // first stage, read only by sync_q
  reg [SW-1:0] sync_q; // second stage, used by logic
  wire [SW-1:0] pins_w = {test_select_i, prog_enable_a_i, prog_enable_b_i,
    prog_enable_c_i, field_selector_i, prog_data_bus_i, cmd_strobe_n_i,
    bus_output_enable_n_i};
  // two-stage capture; reset to the pulled-up levels so that no false
  // strobe or output-enable edge is seen as reset ends
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {SW{1'b1}}; // pulled-up idle levels
      sync_q <= {SW{1'b1}};
    end else if (en_i) begin
      meta_q <= pins_w;
      sync_q <= meta_q;
    end
  end
  // named views of the synchronised pins
  wire strobe_low = !sync_q[1]; // programmer asks for a transfer
  wire oe_low = !sync_q[0]; // programmer lets the port drive
  wire [DW-1:0] data_s = sync_q[DW+1:2]; // word offered on the bus
  wire [3:0] sel_s = sync_q[DW+5:DW+2]; // where the word goes
  // selector and data share the strobe's two-flop delay, so they are
  // read in the same cycle as the strobe edge they belong to
  wire [3:0] strap_s = sync_q[SW-1:SW-4]; // test, enable a, b, c
  // ============================================================
  // mode entry: test, enable a, enable b high, enable c low
  // clock muxing between the external input and the rc source sits
  // outside, in the clock generator; this port only sees clk_i
  reg active_q; // port alive only while straps select the mode
  // registered strap match; a strap glitch costs one cycle of delay but
  // never reaches the pin drivers directly
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) active_q <= 1'b0;
    else if (en_i) active_q <= (strap_s == 4'b1110);
  end
  // mode flag goes out as is, for the pad ring and for test
  assign mode_active_o = active_q;
  // ============================================================
  // command decode, shared by latch and dispatch
  // codes outside this list are stored as no operation, so a slip on the
  // programmer's side can never start an erase or a lock
  function known_cmd;
    input [15:0] c;
    begin
      case (c)
        `FFP_CMD_READ, `FFP_CMD_WP, `FFP_CMD_WPL: known_cmd = 1'b1;
        `FFP_CMD_EWP, `FFP_CMD_CMD_ERASE_PAGE_WRITE_LOCK, `FFP_CMD_EA: known_cmd = 1'b1;
        `FFP_CMD_LOCK_SET, `FFP_CMD_LOCK_CLR,
        `FFP_CMD_NVM_SET, `FFP_CMD_NVM_CLR: known_cmd = 1'b1;
        `FFP_CMD_LOCK_QRY, `FFP_CMD_NVM_QRY,
        `FFP_CMD_SEC_QRY: known_cmd = 1'b1;
        `FFP_CMD_CTRL_SEL, `FFP_CMD_SEC_SET,
        `FFP_CMD_MEM_WR, `FFP_CMD_VER_QRY: known_cmd = 1'b1;
        default: known_cmd = 1'b0; // no operation
      endcase
    end
  endfunction
  // commands whose data handshakes write into the page buffer
  // reads and queries fall through to the read path
  function is_write_cmd;
    input [15:0] c;
    begin
      case (c)
        `FFP_CMD_WP, `FFP_CMD_WPL, `FFP_CMD_EWP, `FFP_CMD_CMD_ERASE_PAGE_WRITE_LOCK,
        `FFP_CMD_MEM_WR: is_write_cmd = 1'b1;
        default: is_write_cmd = 1'b0;
      endcase
    end
  endfunction
  // ============================================================
  // handshake state machine, one-hot
  // one-hot so each state is one flop and its decode a single bit
  localparam [5:0] S_IDLE = 6'b000001; // ready high, wait strobe low
  localparam [5:0] S_EXEC = 6'b000010; // push request to fifo
  localparam [5:0] S_RWAIT = 6'b000100; // wait flash answer
  localparam [5:0] S_OEW = 6'b001000; // wait output enable low
  localparam [5:0] S_DRIVE = 6'b010000; // driving, wait oe high
  localparam [5:0] S_DONE = 6'b100000; // wait strobe high
  // each register pairs with its next value, computed in one place
  reg [5:0] st_q, st_d;
  reg [15:0] cmd_q, cmd_d; // current command
  reg [31:0] addr_q, addr_d; // internal address
  reg [DW-1:0] wdata_q, wdata_d; // data register
  reg [DW-1:0] rdata_q, rdata_d; // word shown on reads
  reg dirty_q, dirty_d; // page buffer holds unflushed words
  reg [31:0] page_q, page_d; // page of buffered words
  reg [1:0] kind_q, kind_d; // pending request kind
  reg flush_first_q, flush_first_d; // flush must precede the request
  reg drive_q, drive_d; // data bus output enable
  wire push_ready; // fifo has room for one more request
  // bytes per data word; kept 32 bits wide so the address sum does not
  // lose the step to truncation
  wire [31:0] step = DW / 8;
  // page number of the current address; a change means the buffered
  // words belong to another page and must be written out first
  wire [31:0] page_of_addr = addr_q >> PAGE_BITS;
  // next-state logic: every register holds unless a branch below moves it
  always @* begin
    st_d = st_q;
    cmd_d = cmd_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    dirty_d = dirty_q;
    page_d = page_q;
    kind_d = kind_q;
    flush_first_d = flush_first_q;
    drive_d = drive_q;
    case (st_q)
      S_IDLE: begin
        // sample only once the strobe falls
        if (active_q && strobe_low) begin
          st_d = S_DONE;
          case (sel_s)
            `FFP_SEL_CMD: begin
              cmd_d = known_cmd(data_s) ? data_s : `FFP_CMD_NONE;
              kind_d = 2'd3;
              flush_first_d = dirty_q; // new command flushes
              st_d = S_EXEC;
            end
            // address bytes only use the low data byte
            `FFP_SEL_ADDR_A: addr_d[7:0] = data_s[7:0];
            `FFP_SEL_ADDR_B: addr_d[15:8] = data_s[7:0];
            `FFP_SEL_ADDR_C: addr_d[23:16] = data_s[7:0];
            `FFP_SEL_ADDR_D: addr_d[31:24] = data_s[7:0];
            `FFP_SEL_DATA: begin
              // a data handshake with no valid command is taken and dropped
              if (cmd_q != `FFP_CMD_NONE) begin
                wdata_d = data_s;
                kind_d = is_write_cmd(cmd_q) ? 2'd0 : 2'd1;
                // leaving the buffered page forces a flush
                flush_first_d = dirty_q && (page_of_addr != page_q);
                st_d = S_EXEC;
              end
            end
            default: st_d = S_DONE; // selector codes 6 to 15 latch nothing
          endcase
        end
      end
      S_EXEC: begin
        // a full fifo parks the port here with ready low, which is how
        // a slow flash controller pushes back on the programmer
        if (push_ready) begin
          // the flush goes out first, the request itself a cycle later
          if (flush_first_q) begin
            flush_first_d = 1'b0;
            dirty_d = 1'b0;
          end else begin
            case (kind_q)
              2'd0: begin
                // write data lands in the page buffer and marks it dirty
                dirty_d = 1'b1;
                page_d = page_of_addr;
                addr_d = addr_q + step;
                st_d = S_DONE;
              end
              2'd1: st_d = S_RWAIT;
              default: st_d = S_DONE;
            endcase
          end
        end
      end
      S_RWAIT: begin
        // the answer is a single-cycle pulse, so it is caught here and
        // held in rdata_q for as long as the programmer needs it
        if (rsp_valid_i) begin
          rdata_d = rsp_data_i;
          addr_d = addr_q + step;
          st_d = S_OEW;
        end
      end
      S_OEW: begin
        // the programmer has let go of the bus only once it pulls output
        // enable low; turning earlier would fight its drivers
        if (oe_low) begin
          drive_d = 1'b1; // bus turns only on output enable
          st_d = S_DRIVE;
        end
      end
      S_DRIVE: begin
        // the bus is let go as soon as output enable rises
        if (!oe_low) begin
          drive_d = 1'b0; // release bus, valid rises
          st_d = S_DONE;
        end
      end
      S_DONE: begin
        // ready only returns after the strobe is seen high, so one long
        // strobe can never be taken as two commands
        if (!strobe_low) st_d = S_IDLE; // ready returns
      end
      default: st_d = S_IDLE;
    endcase
  end
  // state registers; en_i low freezes everything
  // all handshake state lives in these flops, so holding en_i low stops
  // the port mid-transfer and it resumes exactly where it left off
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      cmd_q <= `FFP_CMD_NONE;
      addr_q <= `FFP_RST_ADDR;
      wdata_q <= {DW{1'b0}};
      rdata_q <= {DW{1'b0}};
      dirty_q <= 1'b0;
      page_q <= `FFP_RST_ADDR;
      kind_q <= 2'd0;
      flush_first_q <= 1'b0;
      drive_q <= 1'b0;
    end else if (en_i) begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      dirty_q <= dirty_d;
      page_q <= page_d;
      kind_q <= kind_d;
      flush_first_q <= flush_first_d;
      drive_q <= drive_d;
    end
  end
  // ============================================================
  // request fifo toward the flash controller; a stalled controller
  // holds the port busy, so ready stays low until room returns
  localparam FW = 2 + 16 + 32 + DW; // kind, command, address, data
  // one push per cycle spent in the execute state
  wire push = (st_q == S_EXEC);
  // a pending flush travels as its own request kind ahead of the access
  wire [1:0] push_kind = flush_first_q ? 2'd2 : kind_q;
  // head of the fifo, unpacked onto the request ports below
  wire [FW-1:0] fifo_out;
  ffp_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .en_i(en_i),
    .in_valid_i(push),
    .in_ready_o(push_ready),
    .in_data_i({push_kind, cmd_q, addr_q, wdata_q}),
    .out_valid_o(req_valid_o),
    .out_ready_i(req_ready_i),
    .out_data_o(fifo_out)
  );
  // request fields, in the order they were packed into the fifo
  assign req_kind_o = fifo_out[FW-1:FW-2];
  assign req_cmd_o = fifo_out[FW-3:FW-18];
  assign req_addr_o = fifo_out[DW+31:DW];
  assign req_data_o = fifo_out[DW-1:0];
  // ============================================================
  // pin drivers: everything an input until the mode is entered
  // the enables stay low through reset and until the straps are seen, so
  // the pads fall back on their pull-ups; the data bus needs both the
  // mode and a read in its output phase before it turns around
  assign port_ready_out_o = (st_q == S_IDLE);
  assign port_ready_out_oe_o = active_q;
  assign bus_valid_out_n_o = !drive_q; // low while outputting
  assign bus_valid_out_oe_o = active_q;
  assign prog_data_bus_o = rdata_q;
  assign prog_data_bus_oe_o = drive_q && active_q;
endmodule // ffp_port

// file: verification/ffp_port_asserts.sv
`timescale 1ns/1ns
// ============================================================
// port checker: handshake timing seen at the top pins
module ffp_port_asserts #(
  parameter DW = 16
) (
  // clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // straps and handshake pins
  input wire test_select_i,
  input wire cmd_strobe_n_i,
  input wire bus_output_enable_n_i,
  input wire mode_active_o,
  input wire [DW-1:0] prog_data_bus_o,
  input wire prog_data_bus_oe_o,
  input wire port_ready_out_o,
  input wire port_ready_out_oe_o,
  input wire bus_valid_out_n_o,
  input wire bus_valid_out_oe_o,
  // request stream
  input wire req_valid_o,
  input wire req_ready_i,
  input wire [1:0] req_kind_o,
  input wire [31:0] req_addr_o,
  input wire [DW-1:0] req_data_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // ready may only drop while the programmer holds the strobe low
  a_ready_on_strobe: assert property ($fell(port_ready_out_o) |-> !cmd_strobe_n_i)
    else $error("ready dropped without strobe");
  a_ready_after_high: assert property ($rose(port_ready_out_o)
    |-> $past(cmd_strobe_n_i, 1) && $past(cmd_strobe_n_i, 2))
    else $error("ready rose before strobe seen high");
  a_drive_busy_only: assert property (prog_data_bus_oe_o |-> !port_ready_out_o)
    else $error("bus driven while ready");
  a_valid_with_drive: assert property (prog_data_bus_oe_o |-> !bus_valid_out_n_o)
    else $error("valid high while driving");
  a_release_on_oe: assert property (bus_output_enable_n_i [*4] |-> !prog_data_bus_oe_o)
    else $error("bus driven without output enable");
  a_pins_follow_mode: assert property (!test_select_i [*5] |-> !port_ready_out_oe_o
    && !bus_valid_out_oe_o && !prog_data_bus_oe_o)
    else $error("handshake pins driven outside mode");
  a_mode_needs_test: assert property (!test_select_i [*5] |-> !mode_active_o)
    else $error("mode active without test select");
  a_req_held: assert property (req_valid_o && !req_ready_i |=> req_valid_o
    && $stable(req_kind_o) && $stable(req_addr_o) && $stable(req_data_o))
    else $error("request changed before taken");
  a_drive_in_mode: assert property (prog_data_bus_oe_o |-> mode_active_o)
    else $error("bus driven outside mode");
endmodule // ffp_port_asserts

bind ffp_port ffp_port_asserts #(.DW(DW)) i_ffp_port_asserts (.clk_i(clk_i),
  .arst_n_i(arst_n_i), .test_select_i(test_select_i), .cmd_strobe_n_i(cmd_strobe_n_i),
  .bus_output_enable_n_i(bus_output_enable_n_i), .mode_active_o(mode_active_o),
  .prog_data_bus_o(prog_data_bus_o), .prog_data_bus_oe_o(prog_data_bus_oe_o),
  .port_ready_out_o(port_ready_out_o), .port_ready_out_oe_o(port_ready_out_oe_o),
  .bus_valid_out_n_o(bus_valid_out_n_o), .bus_valid_out_oe_o(bus_valid_out_oe_o),
  .req_valid_o(req_valid_o), .req_ready_i(req_ready_i), .req_kind_o(req_kind_o),
  .req_addr_o(req_addr_o), .req_data_o(req_data_o));

// file: verification/ffp_flash_model.sv
`timescale 1ns/1ns
// ============================================================
// flash controller stand-in: takes requests, answers reads late
module ffp_flash_model (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  input wire stall_i, // holds requests back so the port fifo fills
  // request stream
  input wire req_valid_i,
  output wire req_ready_o,
  input wire [1:0] req_kind_i,
  input wire [15:0] req_cmd_i,
  input wire [31:0] req_addr_i,
  input wire [15:0] req_data_i,
  // read answer and log
  output reg rsp_valid_o,
  output reg [15:0] rsp_data_o,
  output reg [7:0] n_req_o,
  output reg [7:0] n_flush_o,
  output reg [65:0] last_o // kind, command, address, data
);
  reg [2:0] dly_q; // cycles left until the read answer
  reg [15:0] ans_q; // answer word kept for the pulse
  assign req_ready_o = !stall_i;
  // ============================================================
  // request log and delayed answer
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {rsp_valid_o, rsp_data_o, n_req_o, n_flush_o, last_o, dly_q, ans_q} <= 0;
    end else begin
      rsp_valid_o <= 1'b0;
      rsp_data_o <= ~rsp_data_o; // a stale answer never lingers on the lines
      if (dly_q == 3'h1) begin
        rsp_valid_o <= 1'b1; // one-cycle pulse
        rsp_data_o <= ans_q;
      end
      if (dly_q != 3'h0) dly_q <= dly_q - 3'h1;
      if (req_valid_i && req_ready_o) begin
        n_req_o <= n_req_o + 8'h01;
        last_o <= {req_kind_i, req_cmd_i, req_addr_i, req_data_i};
        if (req_kind_i == 2'h2) n_flush_o <= n_flush_o + 8'h01;
        if (req_kind_i == 2'h1) begin
          dly_q <= 3'h3; // slow answer, not in the request cycle
          ans_q <= req_addr_i[15:0] ^ 16'h5A5A;
        end
      end
    end
  end
endmodule // ffp_flash_model

// file: verification/ffp_port_bench.sv
`timescale 1ns/1ns
`include "ffp_defines.vh"
// ============================================================
// bench for the programming port with a flash controller model
module ffp_port_bench;
  reg clk = 0, arst_n = 0, strobe_n = 1, oe_n = 1, drv = 1, tst = 1, stall = 0;
  reg en = 1, pc = 0; // clock enable and third strap, swept near the end
  reg [3:0] sel = 4'h0;
  reg [15:0] pd = 16'h0000, d1, d2;
  reg [31:0] a;
  reg [7:0] f;
  integer seed = 24, errors = 0, n_tests = 0, i;
  wire [15:0] bus_o, rd, rspd;
  wire [15:0] rc;
  wire [31:0] ra;
  wire [1:0] rk;
  wire [7:0] nreq, nfl;
  wire [65:0] last;
  wire bus_oe, mode, rdy, rdy_oe, vn, vn_oe, rv, rr, rspv;
  // released bus reads as all ones through the pull-ups
  wire [15:0] bus_i = bus_oe ? bus_o : (drv ? pd : 16'hFFFF);
  // command table, the unknown code last
  reg [287:0] tab = {`FFP_CMD_READ, `FFP_CMD_WP, `FFP_CMD_WPL, `FFP_CMD_EWP, `FFP_CMD_CMD_ERASE_PAGE_WRITE_LOCK,
    `FFP_CMD_EA, `FFP_CMD_LOCK_SET, `FFP_CMD_LOCK_CLR, `FFP_CMD_LOCK_QRY, `FFP_CMD_NVM_SET,
    `FFP_CMD_NVM_CLR, `FFP_CMD_NVM_QRY, `FFP_CMD_SEC_SET, `FFP_CMD_SEC_QRY, `FFP_CMD_MEM_WR,
    `FFP_CMD_CTRL_SEL, `FFP_CMD_VER_QRY, 16'h0077};
  initial begin
    forever #25 clk = ~clk;
  end
  ffp_port i_ffp_port (.clk_i(clk), .en_i(en), .arst_n_i(arst_n), .test_select_i(tst),
    .prog_enable_a_i(1'b1), .prog_enable_b_i(1'b1), .prog_enable_c_i(pc),
    .mode_active_o(mode), .cmd_strobe_n_i(strobe_n), .bus_output_enable_n_i(oe_n),
    .field_selector_i(sel), .prog_data_bus_i(bus_i), .prog_data_bus_o(bus_o),
    .prog_data_bus_oe_o(bus_oe), .port_ready_out_o(rdy), .port_ready_out_oe_o(rdy_oe),
    .bus_valid_out_n_o(vn), .bus_valid_out_oe_o(vn_oe), .req_valid_o(rv), .req_ready_i(rr),
    .req_cmd_o(rc), .req_addr_o(ra), .req_kind_o(rk), .req_data_o(rd), .rsp_valid_i(rspv),
    .rsp_data_i(rspd));
  ffp_flash_model i_ffp_flash_model (.clk_i(clk), .rst_n_i(arst_n), .stall_i(stall),
    .req_valid_i(rv), .req_ready_o(rr), .req_kind_i(rk), .req_cmd_i(rc), .req_addr_i(ra),
    .req_data_i(rd), .rsp_valid_o(rspv), .rsp_data_o(rspd), .n_req_o(nreq),
    .n_flush_o(nfl), .last_o(last));
  // ============================================================
  // compare, bounded wait, verdict
  task check(input [65:0] seen, input [65:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  // waits on ready (which 0) or valid_n (which 1), never longer than 300 cycles
  task wait_on(input which, input v);
    integer k;
    begin
      for (k = 0; k < 300 && (which ? vn : rdy) !== v; k = k + 1) @(negedge clk);
      if ((which ? vn : rdy) !== v) begin
        errors = errors + 1;
        results;
      end
    end
  endtask
  // ============================================================
  // programmer handshakes, driven on falling edges
  task hs_write(input [3:0] s, input [15:0] d, input hold);
    begin
      @(negedge clk);
      sel = s;
      pd = d;
      strobe_n = 1'b0;
      wait_on(0, 1'b0);
      @(negedge clk);
      strobe_n = 1'b1;
      if (hold) begin
        repeat (30) @(negedge clk);
        check(rdy, 1'b0); // full fifo keeps the port busy
        stall = 1'b0;
      end
      wait_on(0, 1'b1);
      repeat (4) @(negedge clk);
    end
  endtask
  task hs_read(input [15:0] exp);
    begin
      @(negedge clk);
      sel = `FFP_SEL_DATA;
      strobe_n = 1'b0;
      wait_on(0, 1'b0);
      @(negedge clk);
      drv = 1'b0;
      oe_n = 1'b0;
      wait_on(1, 1'b0);
      check({bus_oe, bus_i}, {1'b1, exp});
      @(negedge clk);
      oe_n = 1'b1;
      wait_on(1, 1'b1);
      check(bus_oe, 1'b0);
      @(negedge clk);
      drv = 1'b1;
      strobe_n = 1'b1;
      wait_on(0, 1'b1);
    end
  endtask
  task set_addr(input [31:0] v);
    integer j;
    begin
      for (j = 0; j < 4; j = j + 1) hs_write(j + 1, {8'h00, v[8*j +: 8]}, 1'b0);
    end
  endtask
  // ============================================================
  // main sequence
  initial begin
    repeat (8) @(negedge clk);
    check({bus_oe, rdy_oe, vn_oe, rdy, vn, rv}, 6'b000110);
    arst_n = 1'b1;
    repeat (10) @(negedge clk);
    check({mode, rdy_oe, vn_oe}, 3'b111);
    $display("reset and mode test done");
    for (i = 17; i >= 0; i = i - 1) begin
      hs_write(`FFP_SEL_CMD, tab[i*16 +: 16], 1'b0);
      check(last[65:48], {2'h3, i == 0 ? 16'h0000 : tab[i*16 +: 16]});
    end
    $display("command decode test done");
    hs_write(`FFP_SEL_CMD, `FFP_CMD_WP, 1'b0);
    a = {$random(seed), 8'hFE};
    d1 = $random(seed);
    d2 = $random(seed);
    set_addr(a);
    hs_write(`FFP_SEL_DATA, d1, 1'b0);
    check({last[65:64], last[47:0]}, {2'h0, a, d1});
    f = nfl;
    hs_write(`FFP_SEL_DATA, d2, 1'b0);
    check({nfl - f, last[47:0]}, {8'h01, a + 32'h2, d2});
    f = nreq;
    for (i = 6; i < 16; i = i + 1) hs_write(i, $random(seed), 1'b0);
    check(nreq, f);
    $display("page write test done");
    hs_write(`FFP_SEL_CMD, `FFP_CMD_READ, 1'b0);
    a = {$random(seed), 8'h40};
    set_addr(a);
    hs_read(a[15:0] ^ 16'h5A5A);
    hs_read((a[15:0] + 16'h2) ^ 16'h5A5A);
    $display("read test done");
    hs_write(`FFP_SEL_CMD, `FFP_CMD_WP, 1'b0);
    set_addr(32'h0000_1000);
    hs_write(`FFP_SEL_DATA, $random(seed), 1'b0);
    f = nreq;
    stall = 1'b1;
    for (i = 0; i < 8; i = i + 1) hs_write(`FFP_SEL_DATA, $random(seed), 1'b0);
    hs_write(`FFP_SEL_DATA, $random(seed), 1'b1);
    repeat (8) @(negedge clk); // let the model drain the fifo
    check(nreq - f, 8'h09);
    $display("fifo fill test done");
    en = 1'b0;
    pc = 1'b1;
    repeat (10) @(negedge clk);
    check(mode, 1'b1); // frozen port keeps its mode
    en = 1'b1;
    repeat (10) @(negedge clk);
    check(mode, 1'b0); // third strap high leaves the mode
    pc = 1'b0;
    repeat (10) @(negedge clk);
    check(mode, 1'b1);
    $display("freeze and strap test done");
    tst = 1'b0;
    repeat (10) @(negedge clk);
    check({mode, rdy_oe}, 2'b00);
    $display("mode exit test done");
    results;
  end
endmodule // ffp_port_bench
